/* dv/pvs_mgmt_master.sv */
`timescale 1ns/100ps
module pvs_mgmt_master (
	input logic clock_in,
	output logic frame_start_out = 1'b0,
	output logic bit_valid_out = 1'b0,
	output logic bit_out = 1'b0
);
	// ----------------------------------------
	// Address phase of a management frame
	// ----------------------------------------
	task automatic send_addr(input logic [4:0] a, input int gap);
		@(posedge clock_in) #2 frame_start_out = 1'b1;
		for (int i = 4; i >= 0; i--) begin
			repeat (gap) begin
				@(posedge clock_in) #2 frame_start_out = 1'b0;
				bit_valid_out = 1'b0;
				bit_out = ~bit_out;
			end
			@(posedge clock_in) #2 frame_start_out = 1'b0;
			bit_valid_out = 1'b1;
			bit_out = a[i];
		end
		// Line is not held after the field, so a stale bit cannot pass as data
		@(posedge clock_in) #2 bit_valid_out = 1'b0;
		bit_out = ~bit_out;
	endtask
endmodule // pvs_mgmt_master

/* dv/pvs_regs_checker.sv */
`timescale 1ns/100ps
module pvs_regs_checker
	import pvs_pkg::*;
(
	input logic clock_in,
	input logic resetn_in,
	input logic [4:0] reg_addr_in,
	input logic reg_rd_in,
	input logic reg_wr_in,
	input logic [15:0] reg_rdata_out,
	input logic reg_hit_out,
	input logic read_clear_out,
	input logic addr_frame_start_in,
	input logic addr_match_out,
	input logic polarity_reversed_in,
	input logic speed_10m_in,
	input logic full_duplex_in,
	input logic link_pulse_enable_out,
	input logic force_good_link_out,
	input logic heartbeat_enable_out,
	input logic jabber_guard_enable_out,
	input pvs_an_state_t autoneg_state_in
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	wire mapped = reg_addr_in == 5'h11 || reg_addr_in == 5'h12;
	wire rd_stat = reg_rd_in && reg_addr_in == 5'h11;
	wire rd_cfg = reg_rd_in && reg_addr_in == 5'h12;
	property p_rsvd; rd_stat |=> reg_rdata_out[11:9] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
	property p_ro; rd_cfg |=> !reg_rdata_out[15] && reg_rdata_out[9:1] == 9'h0; endproperty
	a_ro: assert property (p_ro) else $error("config reserved bits set");
	property p_mon; rd_stat |=> reg_rdata_out[3:0] == $past(autoneg_state_in, 2); endproperty
	a_mon: assert property (p_mon) else $error("monitor nibble stale");
	property p_hit; reg_rd_in || reg_wr_in |=> reg_hit_out == $past(mapped); endproperty
	a_hit: assert property (p_hit) else $error("hit wrong");
	property p_clr; rd_stat || rd_cfg |=> read_clear_out; endproperty
	a_clr: assert property (p_clr) else $error("no read clear pulse");
	// Six stable samples cover the two sync flops and the status flop
	property p_pol; (polarity_reversed_in [*6]) ##0 rd_cfg |=> reg_rdata_out[0]; endproperty
	a_pol: assert property (p_pol) else $error("polarity flag missing");
	property p_lnk;
		$past(resetn_in) && $past(speed_10m_in) |-> link_pulse_enable_out != force_good_link_out;
	endproperty
	a_lnk: assert property (p_lnk) else $error("link pulse controls clash");
	property p_hb; $past(full_duplex_in) |-> !heartbeat_enable_out; endproperty
	a_hb: assert property (p_hb) else $error("heartbeat in full duplex");
	property p_jab; $past(resetn_in) && !$past(speed_10m_in) |-> jabber_guard_enable_out; endproperty
	a_jab: assert property (p_jab) else $error("jabber guard off");
	property p_frm; addr_frame_start_in |=> !addr_match_out; endproperty
	a_frm: assert property (p_frm) else $error("match kept over frame start");
	c_stat: cover property (rd_stat);
	c_match: cover property (addr_match_out);
	c_pol: cover property (rd_cfg && polarity_reversed_in);
endmodule // pvs_regs_checker

bind pvs_regs pvs_regs_checker u_pvs_regs_checker (.clock_in, .resetn_in, .reg_addr_in,
	.reg_rd_in, .reg_wr_in, .reg_rdata_out, .reg_hit_out, .read_clear_out, .addr_frame_start_in,
	.addr_match_out, .polarity_reversed_in, .speed_10m_in, .full_duplex_in,
	.link_pulse_enable_out, .force_good_link_out, .heartbeat_enable_out,
	.jabber_guard_enable_out, .autoneg_state_in);

/* dv/pvs_regs_tb_top.sv */
`timescale 1ns/100ps
module pvs_regs_tb_top
	import pvs_pkg::*;
;
	logic clock_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic [4:0] reg_addr_in = 5'h0, addr_strap_in;
	logic [15:0] reg_wdata_in = 16'h0, reg_rdata_out, d;
	logic polarity_reversed_in = 1'b0, autoneg_mode_in = 1'b0, autoneg_done_in = 1'b0;
	logic speed_10m_in = 1'b0, full_duplex_in = 1'b0, loopback_in = 1'b0;
	logic addr_frame_start_in, addr_bit_valid_in, addr_bit_in, addr_match_out;
	logic reg_hit_out, read_clear_out, link_pulse_enable_out, force_good_link_out;
	logic heartbeat_enable_out, squelch_normal_out, jabber_guard_enable_out;
	pvs_res_mode_t resolved_mode_in = PVS_RES_SLOW_HALF;
	pvs_an_state_t autoneg_state_in = PVS_AN_IDLE;
	int n_fail = 0, checks_done = 0, e_cfg = 16'h7800, e_mode = 15, e_mon = 0, e_addr, a;

	pvs_regs u_pvs_regs (.clock_in, .resetn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
		.reg_wdata_in, .reg_rdata_out, .reg_hit_out, .read_clear_out, .addr_frame_start_in,
		.addr_bit_valid_in, .addr_bit_in, .addr_match_out, .addr_strap_in,
		.polarity_reversed_in, .autoneg_mode_in, .autoneg_done_in, .resolved_mode_in,
		.autoneg_state_in, .speed_10m_in, .full_duplex_in, .loopback_in,
		.link_pulse_enable_out, .force_good_link_out, .heartbeat_enable_out,
		.squelch_normal_out, .jabber_guard_enable_out);
	pvs_mgmt_master u_pvs_mgmt_master (.clock_in, .frame_start_out(addr_frame_start_in),
		.bit_valid_out(addr_bit_valid_in), .bit_out(addr_bit_in));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [4:0] ad, input logic [15:0] wd, input int ex);
		@(posedge clock_in) #2 reg_addr_in = ad;
		reg_wr_in = w;
		reg_rd_in = !w;
		reg_wdata_in = wd;
		@(posedge clock_in) #2 reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		chk("hit", 16'(reg_hit_out), 16'(ad == 5'h11 || ad == 5'h12));
		chk("read_clear", 16'(read_clear_out), 16'(!w && (ad == 5'h11 || ad == 5'h12)));
		if (!w) chk("rdata", reg_rdata_out, 16'(ex));
	endtask
	function automatic int stat_exp();
		return (e_mode << 12) | (e_addr << 4) | e_mon;
	endfunction
	task automatic end_of_test();
		$display("checks_done %0d n_fail %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and scenarios
	// ----------------------------------------
	initial forever #12.5 clock_in = ~clock_in;
	initial begin
		repeat (20000) @(posedge clock_in);
		n_fail++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hfa4a0952));
		addr_strap_in = 5'($urandom);
		e_addr = addr_strap_in;
		repeat (12) @(posedge clock_in);
		#2 resetn_in = 1'b1;
		// Strap needs both synchroniser stages before the station address holds it
		repeat (3) @(posedge clock_in);
		acc(0, 5'h11, 0, stat_exp());
		acc(0, 5'h12, 0, e_cfg);
		acc(0, 5'h13, 0, 0);
		acc(1, 5'h11, 16'hffff, 0);
		e_addr = 31;
		acc(0, 5'h11, 0, stat_exp());
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? e_addr : $urandom_range(30);
			u_pvs_mgmt_master.send_addr(5'(a), i);
			chk("addr_match", 16'(addr_match_out), 16'(a == e_addr));
		end
		for (int k = 0; k < 9; k++) begin
			@(posedge clock_in) #2 autoneg_state_in = pvs_an_state_t'(k);
			resolved_mode_in = pvs_res_mode_t'(k % 4);
			autoneg_mode_in = (k != 4);
			autoneg_done_in = 1'b1;
			@(posedge clock_in) #2 autoneg_done_in = 1'b0;
			e_mode = (k == 4) ? e_mode : 1 << (k % 4);
			e_mon = k;
			acc(0, 5'h11, 0, stat_exp());
		end
		for (int k = 0; k < 8; k++) begin
			d = 16'($urandom) & 16'hfbff;
			{speed_10m_in, full_duplex_in, loopback_in} = 3'($urandom);
			acc(1, 5'h12, d, 0);
			e_cfg = d & 16'h7800;
			acc(0, 5'h12, 0, e_cfg);
			chk("controls", {link_pulse_enable_out, force_good_link_out, heartbeat_enable_out,
				squelch_normal_out, jabber_guard_enable_out}, {speed_10m_in & d[14],
				speed_10m_in & !d[14], speed_10m_in & !full_duplex_in & d[13], d[12],
				(speed_10m_in & (full_duplex_in | loopback_in)) ? d[11] : 1'b1});
		end
		for (int p = 1; p >= 0; p--) begin
			polarity_reversed_in = 1'(p);
			repeat (4) @(posedge clock_in);
			acc(0, 5'h12, 0, e_cfg | p);
		end
		end_of_test();
	end
endmodule // pvs_regs_tb_top

/* rtl/pvs_defines.svh */
`ifndef PVS_DEFINES_SVH
`define PVS_DEFINES_SVH

// ----------------------------------------
// Register indices on the management link
// ----------------------------------------
`define PVS_REG_ADDR_W 5
`define PVS_OFS_MODE_STATUS 5'h11
`define PVS_OFS_TENBT_CFG 5'h12

// ----------------------------------------
// Resolved mode status register fields
// ----------------------------------------
`define PVS_MODE_HI 15
`define PVS_MODE_LO 12
`define PVS_MODE_RESET 4'hf
`define PVS_MODE_FAST_FULL 4'h8
`define PVS_MODE_FAST_HALF 4'h4
`define PVS_MODE_SLOW_FULL 4'h2
`define PVS_MODE_SLOW_HALF 4'h1
`define PVS_RSVD_HI 11
`define PVS_RSVD_LO 9
`define PVS_ADDR_HI 8
`define PVS_ADDR_LO 4
`define PVS_ADDR_W 5
`define PVS_STRAP_SETTLE 2'h3
`define PVS_MON_HI 3
`define PVS_MON_LO 0
`define PVS_MON_RESET 4'h0

// ----------------------------------------
// 10BASE-T configuration register fields
// ----------------------------------------
`define PVS_BIT_LINK_PULSE 14
`define PVS_BIT_HEARTBEAT 13
`define PVS_BIT_SQUELCH 12
`define PVS_BIT_JABBER 11
`define PVS_BIT_RSVD_RW 10
`define PVS_BIT_POLARITY 0
`define PVS_CFG_ON_RESET 1'h1
`define PVS_CFG_OFF_RESET 1'h0

`endif

/* rtl/pvs_pkg.sv */
package pvs_pkg;

	// Auto-negotiation monitor codes shown in the low nibble of the status register
	typedef enum logic [3:0] {
		PVS_AN_IDLE = 4'h0,
		PVS_AN_ABILITY_MATCH = 4'h1,
		PVS_AN_ACK_MATCH = 4'h2,
		PVS_AN_ACK_FAIL = 4'h3,
		PVS_AN_CONSIST_MATCH = 4'h4,
		PVS_AN_CONSIST_FAIL = 4'h5,
		PVS_AN_PD_READY = 4'h6,
		PVS_AN_PD_FAIL = 4'h7,
		PVS_AN_COMPLETE = 4'h8
	} pvs_an_state_t;

	// Resolved speed and duplex reported by the negotiation engine
	typedef enum logic [1:0] {
		PVS_RES_SLOW_HALF = 2'h0,
		PVS_RES_SLOW_FULL = 2'h1,
		PVS_RES_FAST_HALF = 2'h2,
		PVS_RES_FAST_FULL = 2'h3
	} pvs_res_mode_t;

endpackage

/* rtl/pvs_regs.sv */
`timescale 1ns/100ps
`include "pvs_defines.svh"

// Contract
// - In auto-negotiation mode, on negotiation done, write one-hot resolved mode into status bits 15:12.
// - Resolved mode bits are read-only, reset to ones, meaningless outside negotiation.
// - Station address travels on the link MSB first, starting with bit 4.
// - Monitor nibble shows idle, ability, ack, ack fail, consistency, consistency fail.
// - Monitor nibble shows parallel detect ready 6, fail 7, negotiation done 8.
// - Status bits 11:9 read zero; writes to them are dropped.
// - Config bit 14 enables link pulses; cleared forces good link; 10M only.
// - Config bit 13 enables heartbeat in 10M; ignored in full duplex.
// - Config bit 11 enables jabber in 10M full duplex or loop-back.
// - Config bit 0 set on reversed 10M polarity, cleared when polarity correct.
// - Latching status bits clear after management reads their register.

module pvs_regs
	import pvs_pkg::*;
(
	input wire logic clock_in,
	input wire logic resetn_in,
	// Register access from the management frame engine
	input wire logic [`PVS_REG_ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_hit_out,
	output logic read_clear_out,
	// Serial address phase of a management frame
	input wire logic addr_frame_start_in,
	input wire logic addr_bit_valid_in,
	input wire logic addr_bit_in,
	output logic addr_match_out,
	// Strap and analog-side inputs
	input wire logic [`PVS_ADDR_W-1:0] addr_strap_in,
	input wire logic polarity_reversed_in,
	// Negotiation engine, same clock
	input wire logic autoneg_mode_in,
	input wire logic autoneg_done_in,
	input wire pvs_res_mode_t resolved_mode_in,
	input wire pvs_an_state_t autoneg_state_in,
	input wire logic speed_10m_in,
	input wire logic full_duplex_in,
	input wire logic loopback_in,
	// Effective 10BASE-T controls
	output logic link_pulse_enable_out,
	output logic force_good_link_out,
	output logic heartbeat_enable_out,
	output logic squelch_normal_out,
	output logic jabber_guard_enable_out
);

	// ----------------------------------------
	// Synchronised pin inputs
	// ----------------------------------------
	logic [`PVS_ADDR_W:0] pins_sync;
	logic [`PVS_ADDR_W-1:0] strap_sync;
	logic polarity_sync;

	pvs_sync #(
		.WIDTH(`PVS_ADDR_W + 1)
	) u_pin_sync (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.async_in({polarity_reversed_in, addr_strap_in}),
		.sync_out(pins_sync)
	);

	assign strap_sync = pins_sync[`PVS_ADDR_W-1:0];
	assign polarity_sync = pins_sync[`PVS_ADDR_W];

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire sel_status = (reg_addr_in == `PVS_OFS_MODE_STATUS);
	wire sel_cfg = (reg_addr_in == `PVS_OFS_TENBT_CFG);
	wire wr_status = reg_wr_in && sel_status;
	wire wr_cfg = reg_wr_in && sel_cfg;
	wire rd_any = reg_rd_in && (sel_status || sel_cfg);

	// ----------------------------------------
	// Status register state
	// ----------------------------------------
	logic [3:0] mode_q;
	logic [3:0] mode_d;
	logic [`PVS_ADDR_W-1:0] station_addr_q;
	logic [`PVS_ADDR_W-1:0] station_addr_d;
	logic [1:0] strap_wait_q;
	logic [1:0] strap_wait_d;
	wire strap_loaded = (strap_wait_q == `PVS_STRAP_SETTLE);
	pvs_an_state_t monitor_q;
	logic [3:0] mode_onehot;

	// Resolved mode as one bit per speed and duplex
	always_comb begin
		mode_onehot = `PVS_MODE_SLOW_HALF;
		unique case (resolved_mode_in)
			PVS_RES_FAST_FULL: mode_onehot = `PVS_MODE_FAST_FULL;
			PVS_RES_FAST_HALF: mode_onehot = `PVS_MODE_FAST_HALF;
			PVS_RES_SLOW_FULL: mode_onehot = `PVS_MODE_SLOW_FULL;
			PVS_RES_SLOW_HALF: mode_onehot = `PVS_MODE_SLOW_HALF;
		endcase
	end

	// Updated only by the negotiation engine; bus writes never reach it
	assign mode_d = (autoneg_mode_in && autoneg_done_in) ? mode_onehot : mode_q;

	// Synchroniser is cleared by reset, so the strap is only trusted once it
	// has crossed both stages; a bus write ends the wait so it is not overwritten
	assign strap_wait_d = (wr_status || strap_loaded) ? `PVS_STRAP_SETTLE :
		strap_wait_q + 2'h1;
	assign station_addr_d = wr_status ? reg_wdata_in[`PVS_ADDR_HI:`PVS_ADDR_LO] :
		(!strap_loaded ? strap_sync : station_addr_q);

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			mode_q <= `PVS_MODE_RESET;
			station_addr_q <= '0;
			strap_wait_q <= 2'h0;
			monitor_q <= PVS_AN_IDLE;
		end else begin
			mode_q <= mode_d;
			station_addr_q <= station_addr_d;
			strap_wait_q <= strap_wait_d;
			monitor_q <= autoneg_state_in;
		end
	end

	// ----------------------------------------
	// Serial address match, MSB first
	// ----------------------------------------
	logic [`PVS_ADDR_W-1:0] addr_shift_q;
	logic [2:0] addr_cnt_q;
	logic addr_match_q;
	wire [`PVS_ADDR_W-1:0] addr_shift_next = {addr_shift_q[`PVS_ADDR_W-2:0], addr_bit_in};
	wire addr_last = addr_bit_valid_in && (addr_cnt_q == 3'(`PVS_ADDR_W - 1));

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			addr_shift_q <= '0;
			addr_cnt_q <= '0;
			addr_match_q <= 1'b0;
		end else if (addr_frame_start_in) begin
			addr_cnt_q <= '0;
			addr_match_q <= 1'b0;
		end else if (addr_bit_valid_in && (addr_cnt_q < 3'(`PVS_ADDR_W))) begin
			addr_shift_q <= addr_shift_next;
			addr_cnt_q <= addr_cnt_q + 3'h1;
			addr_match_q <= addr_last && (addr_shift_next == station_addr_q);
		end
	end

	assign addr_match_out = addr_match_q;

	// ----------------------------------------
	// 10BASE-T configuration state
	// ----------------------------------------
	logic link_pulse_q;
	logic heartbeat_q;
	logic squelch_q;
	logic jabber_q;
	logic rsvd_rw_q;
	logic polarity_q;

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			link_pulse_q <= `PVS_CFG_ON_RESET;
			heartbeat_q <= `PVS_CFG_ON_RESET;
			squelch_q <= `PVS_CFG_ON_RESET;
			jabber_q <= `PVS_CFG_ON_RESET;
			rsvd_rw_q <= `PVS_CFG_OFF_RESET;
			polarity_q <= `PVS_CFG_OFF_RESET;
		end else begin
			if (wr_cfg) begin
				link_pulse_q <= reg_wdata_in[`PVS_BIT_LINK_PULSE];
				heartbeat_q <= reg_wdata_in[`PVS_BIT_HEARTBEAT];
				squelch_q <= reg_wdata_in[`PVS_BIT_SQUELCH];
				jabber_q <= reg_wdata_in[`PVS_BIT_JABBER];
				rsvd_rw_q <= reg_wdata_in[`PVS_BIT_RSVD_RW];
			end
			// Follows the detector both ways, not sticky
			polarity_q <= polarity_sync;
		end
	end

	// ----------------------------------------
	// Effective controls to the 10BASE-T logic
	// ----------------------------------------
	// Outside 10M these bits, except squelch bit 12, have no say and the block falls back to normal operation
	logic link_pulse_q2;
	logic force_link_q;
	logic heartbeat_eff_q;
	logic squelch_eff_q;
	logic jabber_eff_q;
	wire jabber_mode = speed_10m_in && (full_duplex_in || loopback_in);

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			link_pulse_q2 <= 1'b0;
			force_link_q <= 1'b0;
			heartbeat_eff_q <= 1'b0;
			squelch_eff_q <= 1'b0;
			jabber_eff_q <= 1'b0;
		end else begin
			link_pulse_q2 <= speed_10m_in && link_pulse_q;
			force_link_q <= speed_10m_in && !link_pulse_q;
			heartbeat_eff_q <= speed_10m_in && !full_duplex_in && heartbeat_q;
			squelch_eff_q <= squelch_q;
			jabber_eff_q <= jabber_mode ? jabber_q : 1'b1;
		end
	end

	assign link_pulse_enable_out = link_pulse_q2;
	assign force_good_link_out = force_link_q;
	assign heartbeat_enable_out = heartbeat_eff_q;
	assign squelch_normal_out = squelch_eff_q;
	assign jabber_guard_enable_out = jabber_eff_q;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	wire [15:0] status_word = {mode_q, 3'h0, station_addr_q, monitor_q};
	wire [15:0] cfg_word = {1'b0, link_pulse_q, heartbeat_q, squelch_q, jabber_q,
		rsvd_rw_q, 9'h000, polarity_q};
	wire [15:0] rdata_mux = sel_status ? status_word : (sel_cfg ? cfg_word : 16'h0000);

	logic [15:0] rdata_q;
	logic hit_q;
	logic read_clear_q;

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			rdata_q <= 16'h0000;
			hit_q <= 1'b0;
			read_clear_q <= 1'b0;
		end else begin
			if (reg_rd_in) begin
				rdata_q <= rdata_mux;
			end
			hit_q <= (reg_rd_in || reg_wr_in) && (sel_status || sel_cfg);
			read_clear_q <= rd_any;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign reg_hit_out = hit_q;
	assign read_clear_out = read_clear_q;

endmodule // pvs_regs

/* rtl/pvs_sync.sv */
`timescale 1ns/100ps

module pvs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("pvs_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // pvs_sync
